// ### src/pwmdb_pkg.sv
// package: register offsets, reset values and widths for the pwm duty byte block
package pwmdb_pkg;
  localparam int unsigned    PWMDB_ADDR_W      = 8;
  localparam int unsigned    PWMDB_DATA_W      = 8;
  localparam int unsigned    PWMDB_CHANNELS    = 3;
  localparam logic [7:0]     PWMDB_FLAGS_OFF   = 8'hd0;
  localparam logic [7:0]     PWMDB_D0H_OFF     = 8'hd1;
  localparam logic [7:0]     PWMDB_D0L_OFF     = 8'hd2;
  localparam logic [7:0]     PWMDB_D1H_OFF     = 8'hd3;
  localparam logic [7:0]     PWMDB_D1L_OFF     = 8'hd4;
  localparam logic [7:0]     PWMDB_D2H_OFF     = 8'hd5;
  localparam logic [7:0]     PWMDB_D2L_OFF     = 8'hd6;
  localparam int unsigned    PWMDB_FLAG_B_POS  = 1;
  localparam logic [7:0]     PWMDB_HIGH_RST    = 8'h80;
  localparam logic [7:0]     PWMDB_LOW_RST     = 8'h00;
  localparam logic           PWMDB_FLAG_B_RST  = 1'b0;
endpackage : pwmdb_pkg

// ### src/pwmdb_channel.sv
// one pwm channel: buffered low-byte write and snapshotted low-byte read
`timescale 1ns/100ps
module pwmdb_channel
  import pwmdb_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        srst_i,
  input  wire logic        wr_high_i,
  input  wire logic        wr_low_i,
  input  wire logic        rd_high_i,
  input  wire logic [7:0]  wdata_i,
  output logic      [15:0] duty_o,
  output logic      [7:0]  low_view_o
);
  typedef struct packed {
    logic [15:0] duty;
    logic [7:0]  low_hold;
    logic [7:0]  low_snap;
  } pwmdb_ch_state_t;

  pwmdb_ch_state_t state;
  pwmdb_ch_state_t next_state;

  //////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_state = state;
    if (wr_low_i)
    begin
      next_state.low_hold = wdata_i;
    end
    if (wr_high_i)
    begin
      next_state.duty = {wdata_i, state.low_hold};
    end
    if (rd_high_i)
    begin
      next_state.low_snap = state.duty[7:0];
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      state.duty     <= {PWMDB_HIGH_RST, PWMDB_LOW_RST};
      state.low_hold <= PWMDB_LOW_RST;
      state.low_snap <= PWMDB_LOW_RST;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign duty_o     = state.duty;
  assign low_view_o = state.low_snap;
endmodule // pwmdb_channel

// ### src/pwmdb_top.sv
// pwm duty byte register block: three 16-bit duty values behind byte registers
//
// Added by the designer: strobed register access.
`timescale 1ns/100ps
module pwmdb_top
  import pwmdb_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        srst_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  output logic      [15:0] duty0_o,
  output logic      [15:0] duty1_o,
  output logic      [15:0] duty2_o,
  output logic             user_flag_b_o
);
  typedef struct packed {
    logic [7:0] rdata;
    logic       user_flag_b;
  } pwmdb_state_t;

  pwmdb_state_t state;
  pwmdb_state_t next_state;

  // one decode per mapped register, shared by the write and read paths
  logic         hit_flags;
  logic         hit_d0h;
  logic         hit_d0l;
  logic         hit_d1h;
  logic         hit_d1l;
  logic         hit_d2h;
  logic         hit_d2l;

  // per-channel strobes, bit index is the channel number
  logic [2:0]   wr_high;
  logic [2:0]   wr_low;
  logic [2:0]   rd_high;
  logic [15:0]  duty [3];
  logic [7:0]   low_view [3];
  logic [7:0]   flag_view;
  logic [7:0]   read_value;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // places the flag at its field position, the other bits read zero
  function automatic logic [7:0] flag_byte(input logic f);
    flag_byte                   = 8'h00;
    flag_byte[PWMDB_FLAG_B_POS] = f;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // address decode
  always_comb
  begin
    hit_flags = hit(addr_i, PWMDB_FLAGS_OFF);
    hit_d0h   = hit(addr_i, PWMDB_D0H_OFF);
    hit_d0l   = hit(addr_i, PWMDB_D0L_OFF);
    hit_d1h   = hit(addr_i, PWMDB_D1H_OFF);
    hit_d1l   = hit(addr_i, PWMDB_D1L_OFF);
    hit_d2h   = hit(addr_i, PWMDB_D2H_OFF);
    hit_d2l   = hit(addr_i, PWMDB_D2L_OFF);
  end

  //////////////////////////////////////////////////////////////////////////////
  // strobe decode per channel
  always_comb
  begin
    wr_high = 3'h0;
    wr_low  = 3'h0;
    rd_high = 3'h0;
    if (wr_i)
    begin
      wr_high[0] = hit_d0h;
      wr_low[0]  = hit_d0l;
      wr_high[1] = hit_d1h;
      wr_low[1]  = hit_d1l;
      wr_high[2] = hit_d2h;
      wr_low[2]  = hit_d2l;
    end
    if (rd_i)
    begin
      // a high-byte read freezes the low byte for the read that follows
      rd_high[0] = hit_d0h;
      rd_high[1] = hit_d1h;
      rd_high[2] = hit_d2h;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // channel 0
  pwmdb_channel pwmdb_channel_i0 (
    .ref_clk_i  (ref_clk_i),
    .srst_i     (srst_i),
    .wr_high_i  (wr_high[0]),
    .wr_low_i   (wr_low[0]),
    .rd_high_i  (rd_high[0]),
    .wdata_i    (wdata_i),
    .duty_o     (duty[0]),
    .low_view_o (low_view[0])
  );

  // channel 1
  pwmdb_channel pwmdb_channel_i1 (
    .ref_clk_i  (ref_clk_i),
    .srst_i     (srst_i),
    .wr_high_i  (wr_high[1]),
    .wr_low_i   (wr_low[1]),
    .rd_high_i  (rd_high[1]),
    .wdata_i    (wdata_i),
    .duty_o     (duty[1]),
    .low_view_o (low_view[1])
  );

  // channel 2
  pwmdb_channel pwmdb_channel_i2 (
    .ref_clk_i  (ref_clk_i),
    .srst_i     (srst_i),
    .wr_high_i  (wr_high[2]),
    .wr_low_i   (wr_low[2]),
    .rd_high_i  (rd_high[2]),
    .wdata_i    (wdata_i),
    .duty_o     (duty[2]),
    .low_view_o (low_view[2])
  );

  //////////////////////////////////////////////////////////////////////////////
  // read mux: unmapped addresses read zero
  always_comb
  begin
    flag_view  = flag_byte(state.user_flag_b);
    read_value = 8'h00;
    if (hit_flags)
    begin
      read_value = flag_view;
    end
    if (hit_d0h)
    begin
      read_value = duty[0][15:8];
    end
    if (hit_d0l)
    begin
      read_value = low_view[0];
    end
    if (hit_d1h)
    begin
      read_value = duty[1][15:8];
    end
    if (hit_d1l)
    begin
      read_value = low_view[1];
    end
    if (hit_d2h)
    begin
      read_value = duty[2][15:8];
    end
    if (hit_d2l)
    begin
      read_value = low_view[2];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read data register and flag register
  always_comb
  begin
    next_state       = state;
    next_state.rdata = 8'h00;
    if (wr_i && hit_flags)
    begin
      next_state.user_flag_b = wdata_i[PWMDB_FLAG_B_POS];
    end
    if (rd_i)
    begin
      // read data stand for exactly one cycle, zero otherwise
      next_state.rdata = read_value;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      state.rdata       <= 8'h00;
      state.user_flag_b <= PWMDB_FLAG_B_RST;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign rdata_o       = state.rdata;
  assign user_flag_b_o = state.user_flag_b;
  assign duty0_o       = duty[0];
  assign duty1_o       = duty[1];
  assign duty2_o       = duty[2];
endmodule // pwmdb_top

// ### testbench/pwmdb_props.sv
// checker: port-level properties of the pwm duty byte block
`timescale 1ns/100ps
module pwmdb_props
  import pwmdb_pkg::*;
(
  input wire logic        ref_clk_i,
  input wire logic        srst_i,
  input wire logic [7:0]  addr_i,
  input wire logic [7:0]  wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [7:0]  rdata_o,
  input wire logic [15:0] duty0_o,
  input wire logic [15:0] duty1_o,
  input wire logic [15:0] duty2_o,
  input wire logic        user_flag_b_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  d0_commit_a: assert property (
    wr_i && addr_i == PWMDB_D0H_OFF |=> duty0_o[15:8] == $past(wdata_i)) else $error("d0 hi");
  d0_hold_a: assert property (
    $changed(duty0_o) |-> $past(wr_i && addr_i == PWMDB_D0H_OFF)) else $error("d0 moved");
  d1_commit_a: assert property (
    wr_i && addr_i == PWMDB_D1H_OFF |=> duty1_o[15:8] == $past(wdata_i)) else $error("d1 hi");
  d2_commit_a: assert property (
    wr_i && addr_i == PWMDB_D2H_OFF |=> duty2_o[15:8] == $past(wdata_i)) else $error("d2 hi");
  d0_high_read_a: assert property (
    rd_i && addr_i == PWMDB_D0H_OFF |=> rdata_o == $past(duty0_o[15:8])) else $error("d0 rd");
  d1_high_read_a: assert property (
    rd_i && addr_i == PWMDB_D1H_OFF |=> rdata_o == $past(duty1_o[15:8])) else $error("d1 rd");
  flag_write_a: assert property (
    wr_i && addr_i == PWMDB_FLAGS_OFF |=> user_flag_b_o == $past(wdata_i[1])) else $error("flag");
  reset_value_a: assert property (
    $fell(srst_i) |-> duty0_o == 16'h8000 && duty2_o == 16'h8000) else $error("reset duty");
endmodule // pwmdb_props
bind pwmdb_top pwmdb_props pwmdb_props_i (.*);

// ### testbench/pwmdb_top_test.sv
// testbench: byte ordering checks for the pwm duty byte block
`timescale 1ns/100ps
module pwmdb_top_test;
  import pwmdb_pkg::*;
  logic        clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, flag;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
  logic [15:0] duty [0:2];
  int          bad_count = 0, compares = 0;
  pwmdb_top pwmdb_top_i (.ref_clk_i(clk), .srst_i(srst), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .duty0_o(duty[0]), .duty1_o(duty[1]),
    .duty2_o(duty[2]), .user_flag_b_o(flag));
  initial forever #20 clk = ~clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk({8'h00, rdata}, {8'h00, exp});
    @(posedge clk);
  endtask
  task automatic t_channel(input int ch);
    logic [7:0] h;
    h = PWMDB_D0H_OFF + 8'(2 * ch);
    wr_reg(h + 8'h01, 8'h30 + 8'(ch));
    chk(duty[ch], 16'h8000);
    wr_reg(h, 8'h5a);
    chk(duty[ch], {8'h5a, 8'h30 + 8'(ch)});
    rd_chk(h, 8'h5a);
    wr_reg(h + 8'h01, 8'hc3);
    wr_reg(h, 8'h11);
    chk(duty[ch], 16'h11c3);
    rd_chk(h + 8'h01, 8'h30 + 8'(ch));
    $display("channel %0d done", ch);
  endtask
  task automatic t_flag;
    chk({15'h0000, flag}, 16'h0000);
    wr_reg(PWMDB_FLAGS_OFF, 8'hff);
    rd_chk(PWMDB_FLAGS_OFF, 8'h02);
    chk({15'h0000, flag}, 16'h0001);
    wr_reg(PWMDB_FLAGS_OFF, 8'h00);
    rd_chk(PWMDB_FLAGS_OFF, 8'h00);
    wr_reg(8'hd7, 8'hff);
    rd_chk(8'hd7, 8'h00);
    $display("flag done");
  endtask
  task automatic wrap_up;
    $display("compares=%0d bad=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_flag;
    for (int c = 0; c < 3; c++)
      t_channel(c);
    wrap_up;
  end
  initial
  begin
    repeat (2000) @(posedge clk);
    bad_count++;
    wrap_up;
  end
endmodule // pwmdb_top_test
